// *** hw/ext_cap_defines.vh ***
// Register offsets, field positions and reset values of the extended capability bank.
// Assumes byte-address configuration accesses on dword boundaries.
`ifndef EXT_CAP_DEFINES_VH
`define EXT_CAP_DEFINES_VH

`define OFS_SN_HDR      12'h100
`define OFS_SN_LOW      12'h104
`define OFS_SN_HIGH     12'h108
`define OFS_PB_HDR      12'h138
`define OFS_PB_SELECT   12'h13C
`define OFS_PB_ENTRY    12'h140
`define OFS_PB_ALLOC    12'h144
`define OFS_VC_HDR      12'h148
`define OFS_VC_PORTCAP  12'h14C
`define OFS_VC_CTRL     12'h154
`define OFS_VC0_RCAP    12'h158
`define OFS_VC0_RCTL    12'h15C
`define OFS_VC0_RSTS    12'h160

`define CAP_ID_SN       16'h0003
`define CAP_ID_PB       16'h0004
`define CAP_ID_VC       16'h0002
`define CAP_VERSION     4'h1
`define NEXT_SN         12'hFB4
`define NEXT_PB         12'h148
`define NEXT_VC         12'h000

`define SEL_IDX_HI      7
`define SEL_IDX_LO      0
`define SEL_DATA_HI     28
`define SEL_DATA_LO     8
`define ENTRY_BITS      21
`define SEL_RESET       8'h00
`define ALLOC_RESET     1'b1
`define ARB_SEL_RESET   3'h0
`define ARB_SEL_HI      3
`define ARB_SEL_LO      1
`define TABLE_SIZE_4BIT 2'h2

`endif

// *** hw/budget_entry.v ***
// One power budget entry: 21 bits of descriptor data plus its index match.
// Assumes the write strobe is already qualified by the select register decode.
`timescale 1ns/100ps
`include "ext_cap_defines.vh"

module budget_entry #(
    parameter [7:0] INDEX = 8'h00
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Merged index plus data write
    input wire load,
    input wire [7:0] load_index,
    input wire [`ENTRY_BITS-1:0] load_data,
    // Stored descriptor
    output reg [`ENTRY_BITS-1:0] data
);

    always @(posedge clk) begin
        if (!rstn) begin
            data <= {`ENTRY_BITS{1'b0}};
        end else if (load && (load_index == INDEX)) begin
            data <= load_data;
        end
    end

endmodule

// *** hw/serial_number_store.v ***
// Device serial number, 64 bits, loaded by the initializer and held for all ports.
// Assumes one shared instance feeds every port's read path.
`timescale 1ns/100ps
`include "ext_cap_defines.vh"

module serial_number_store #(
    parameter [63:0] SERIAL_DEFAULT = 64'h0000_0000_0000_0000
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Initializer writes
    input wire load_low,
    input wire load_high,
    input wire [31:0] load_data,
    // Held value
    output reg [63:0] serial
);

    always @(posedge clk) begin
        if (!rstn) begin
            serial <= SERIAL_DEFAULT;
        end else begin
            if (load_low) begin
                serial[31:0] <= load_data;
            end
            if (load_high) begin
                serial[63:32] <= load_data;
            end
        end
    end

endmodule

// *** hw/pcie_ext_capability_regs.v ***
// Extended capability register bank of one switch: serial number, power budget and
// virtual channel structures, one copy of the per-port state for each port.
// Assumes a dword configuration access port with a one-cycle read latency and a
// separate initializer write port that may also load read-only contents.
//
// Operation
// - Serial number header reads ID 0003h, version 1, next offset FB4h.
// - Read-only 64-bit serial number, initializer loaded, same on all ports.
// - Serial low 24 bits company identifier, upper 40 bits extension identifier.
// - Power budget header reads ID 0004h, version 1, next offset 148h.
// - Software writes index to select low byte; entry register shows that entry.
// - Initializer write to select stores bits 28:8 into entry bits 7:0 index.
// - Eight entries per port at index 0 to 7; select resets to 00h.
// - Entry bits 7:0 give base power in watts, scaled by data scale.
// - Entry bits 9:8 scale: 1.0, 0.1, 0.01, 0.001.
// - Entry bits 12:10 sub-state, bits 14:13 device power state.
// - Entry bits 17:15 operating condition type encoding.
// - Entry bits 20:18 supply rail; bits 31:21 reserved.
// - Allocation bit 0 defaults to 1, initializer may change it.
// - Channel header reads ID 0002h, version 1, next offset 000h.
// - Upstream port capability bits 11:10 read 10b; downstream read 00b.
// - Extended count, low-priority count and reference clock fields read zero.
// - Table load trigger bit 0 always reads 0.
// - Arbitration select bits 3:1 reset to 000b; table status reserved.
// - Resource capability bit 0 reads 1; bit 1 only on upstream port.
// - Channel registers exist as an independent copy per port.
`timescale 1ns/100ps
`include "ext_cap_defines.vh"

module pcie_ext_capability_regs #(
    parameter PORTS = 8,
    parameter PORT_BITS = 3,
    parameter ENTRIES = 8,
    parameter [PORT_BITS-1:0] UPSTREAM_PORT = 0,
    // Arbitrary neutral serial default, replaced by the initializer
    parameter [63:0] SERIAL_DEFAULT = 64'h0000_0000_0000_0000
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Host configuration access
    input wire cfg_req,
    input wire cfg_write,
    input wire [PORT_BITS-1:0] cfg_port,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    output reg cfg_ack,
    output reg cfg_hit,
    output reg [31:0] cfg_rdata,
    // Serial EEPROM initializer writes
    input wire init_write,
    input wire [PORT_BITS-1:0] init_port,
    input wire [11:0] init_addr,
    input wire [31:0] init_wdata,
    // Per-port control seen by the arbiters
    output wire [PORTS*3-1:0] vc_arb_select
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared serial number

    wire [63:0] serial;
    wire init_sn_low = init_write && (init_addr == `OFS_SN_LOW);
    wire init_sn_high = init_write && (init_addr == `OFS_SN_HIGH);

    // One store for all ports keeps the ports identical by construction
    serial_number_store #(
        .SERIAL_DEFAULT(SERIAL_DEFAULT)
    ) u_serial (
        .clk(clk),
        .rstn(rstn),
        .load_low(init_sn_low),
        .load_high(init_sn_high),
        .load_data(init_wdata),
        .serial(serial)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-port state

    reg [7:0] pb_select [0:PORTS-1];
    reg [PORTS-1:0] pb_alloc;
    reg [2:0] arb_sel [0:PORTS-1];
    wire [`ENTRY_BITS-1:0] entry_data [0:PORTS*ENTRIES-1];

    wire host_wr = cfg_req && cfg_write;

    genvar p, e;
    generate
        for (p = 0; p < PORTS; p = p + 1) begin : g_port
            wire sel_host = host_wr && (cfg_port == p) && (cfg_addr == `OFS_PB_SELECT);
            wire sel_init = init_write && (init_port == p) && (init_addr == `OFS_PB_SELECT);
            wire alloc_init = init_write && (init_port == p) && (init_addr == `OFS_PB_ALLOC);
            wire ctl_host = host_wr && (cfg_port == p) && (cfg_addr == `OFS_VC_CTRL);
            wire ctl_init = init_write && (init_port == p) && (init_addr == `OFS_VC_CTRL);

            always @(posedge clk) begin
                if (!rstn) begin
                    pb_select[p] <= `SEL_RESET;
                    pb_alloc[p] <= `ALLOC_RESET;
                    arb_sel[p] <= `ARB_SEL_RESET;
                end else begin
                    // Initializer wins when both write the same cycle
                    if (sel_init) begin
                        pb_select[p] <= init_wdata[`SEL_IDX_HI:`SEL_IDX_LO];
                    end else if (sel_host) begin
                        pb_select[p] <= cfg_wdata[`SEL_IDX_HI:`SEL_IDX_LO];
                    end
                    if (alloc_init) begin
                        pb_alloc[p] <= init_wdata[0];
                    end
                    // Only the round-robin code is defined; others are still stored
                    if (ctl_init) begin
                        arb_sel[p] <= init_wdata[`ARB_SEL_HI:`ARB_SEL_LO];
                    end else if (ctl_host) begin
                        arb_sel[p] <= cfg_wdata[`ARB_SEL_HI:`ARB_SEL_LO];
                    end
                end
            end

            assign vc_arb_select[p*3 +: 3] = arb_sel[p];

            for (e = 0; e < ENTRIES; e = e + 1) begin : g_entry
                // Merged index plus data load from the initializer
                budget_entry #(
                    .INDEX(e)
                ) u_entry (
                    .clk(clk),
                    .rstn(rstn),
                    .load(sel_init),
                    .load_index(init_wdata[`SEL_IDX_HI:`SEL_IDX_LO]),
                    .load_data(init_wdata[`SEL_DATA_HI:`SEL_DATA_LO]),
                    .data(entry_data[p*ENTRIES+e])
                );
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    reg [31:0] next_rdata;
    reg next_hit;
    reg [7:0] cur_sel;
    reg is_up;

    always @* begin
        cur_sel = pb_select[cfg_port];
        is_up = (cfg_port == UPSTREAM_PORT);
        next_rdata = 32'h0000_0000;
        next_hit = 1'b1;
        case (cfg_addr)
            `OFS_SN_HDR: begin
                next_rdata = {`NEXT_SN, `CAP_VERSION, `CAP_ID_SN};
            end
            `OFS_SN_LOW: begin
                // Company identifier sits in bits 23:0 of the low dword
                next_rdata = serial[31:0];
            end
            `OFS_SN_HIGH: begin
                next_rdata = serial[63:32];
            end
            `OFS_PB_HDR: begin
                next_rdata = {`NEXT_PB, `CAP_VERSION, `CAP_ID_PB};
            end
            `OFS_PB_SELECT: begin
                next_rdata = {24'h00_0000, cur_sel};
            end
            `OFS_PB_ENTRY: begin
                // Out-of-range index reads as an empty entry
                if (cur_sel < ENTRIES) begin
                    // Fields 8 to 12 are stored verbatim as loaded
                    next_rdata = {11'h000, entry_data[cfg_port*ENTRIES + cur_sel]};
                end
            end
            `OFS_PB_ALLOC: begin
                next_rdata = {31'h0000_0000, pb_alloc[cfg_port]};
            end
            `OFS_VC_HDR: begin
                next_rdata = {`NEXT_VC, `CAP_VERSION, `CAP_ID_VC};
            end
            `OFS_VC_PORTCAP: begin
                // Count and reference clock fields stay zero
                if (is_up) begin
                    next_rdata = {20'h0_0000, `TABLE_SIZE_4BIT, 10'h000};
                end
            end
            `OFS_VC_CTRL: begin
                // Load trigger and table status always read zero
                next_rdata = {28'h000_0000, arb_sel[cfg_port], 1'b0};
            end
            `OFS_VC0_RCAP: begin
                next_rdata = {30'h0000_0000, is_up, 1'b1};
            end
            `OFS_VC0_RCTL, `OFS_VC0_RSTS: begin
                // Served by neighbouring logic; mapped here as zero
                next_rdata = 32'h0000_0000;
            end
            default: begin
                next_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            cfg_ack <= 1'b0;
            cfg_hit <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack <= cfg_req;
            cfg_hit <= cfg_req && next_hit;
            if (cfg_req && !cfg_write) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

endmodule

// *** bench/ext_cap_checker_asserts.sv ***
// Checker for the extended capability bank: access timing and fixed read fields.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/100ps
module ext_cap_checker #(
    parameter PORTS = 8,
    parameter PORT_BITS = 3,
    parameter [PORT_BITS-1:0] UPSTREAM_PORT = 0
) (
    // Clock, reset and host access
    input wire clk,
    input wire rstn,
    input wire cfg_req,
    input wire cfg_write,
    input wire [PORT_BITS-1:0] cfg_port,
    input wire [11:0] cfg_addr,
    // Answers
    input wire cfg_ack,
    input wire cfg_hit,
    input wire [31:0] cfg_rdata,
    input wire [PORTS*3-1:0] vc_arb_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire rd = cfg_req && !cfg_write;
    wire up = cfg_port == UPSTREAM_PORT;
    wire [2:0] sel_now = vc_arb_select[cfg_port*3 +: 3];

    a_ack_follows: assert property (cfg_req |=> cfg_ack) else $error("ack missing");
    a_no_stray_ack: assert property (!cfg_req |=> !cfg_ack) else $error("stray ack");
    a_rdata_hold: assert property (!rd |=> $stable(cfg_rdata)) else $error("rdata moved");
    a_unmapped_zero: assert property (rd && cfg_addr == 12'h200 |=> !cfg_hit && cfg_rdata == 0)
        else $error("unmapped read");
    a_serial_header: assert property (rd && cfg_addr == 12'h100 |=> cfg_rdata == 32'hFB41_0003)
        else $error("serial header");
    a_budget_header: assert property (rd && cfg_addr == 12'h138 |=> cfg_rdata == 32'h1481_0004)
        else $error("budget header");
    a_channel_header: assert property (rd && cfg_addr == 12'h148 |=> cfg_rdata == 32'h0001_0002)
        else $error("channel header");
    a_port_cap: assert property (rd && cfg_addr == 12'h14C |=>
        cfg_rdata == ($past(up) ? 32'h0000_0800 : 32'h0)) else $error("port cap");
    a_resource_cap: assert property (rd && cfg_addr == 12'h158 |=>
        cfg_rdata == ($past(up) ? 32'h3 : 32'h1)) else $error("resource cap");
    a_control_read: assert property (rd && cfg_addr == 12'h154 |=>
        cfg_rdata == {28'h0, $past(sel_now), 1'b0}) else $error("control read");
    a_select_read: assert property (rd && cfg_addr == 12'h13C |=> cfg_rdata[31:8] == 24'h0)
        else $error("select read");
endmodule

bind pcie_ext_capability_regs ext_cap_checker #(.PORTS(PORTS), .PORT_BITS(PORT_BITS),
    .UPSTREAM_PORT(UPSTREAM_PORT)) chk_u (.clk(clk), .rstn(rstn), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack),
    .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .vc_arb_select(vc_arb_select));

// *** bench/eeprom_init_model.sv ***
// Serial EEPROM initializer model: single-cycle writes, no answer expected.
// Assumes the bench calls load from one process at a time.
`timescale 1ns/100ps
module eeprom_init_model (
    input wire clk,
    output reg init_write,
    output reg [2:0] init_port,
    output reg [11:0] init_addr,
    output reg [31:0] init_wdata
);
    initial begin
        init_write = 1'b0;
        init_port = 3'h0;
        init_addr = 12'hFFF;
        init_wdata = 32'hA5A5_A5A5;
    end
    // Idle data shows the inverse so a stale capture is caught
    task load(input [2:0] p, input [11:0] a, input [31:0] d);
        begin
            @(negedge clk);
            init_write = 1'b1;
            init_port = p;
            init_addr = a;
            init_wdata = d;
            @(negedge clk);
            init_write = 1'b0;
            init_addr = ~a;
            init_wdata = ~d;
        end
    endtask
endmodule

// *** bench/pcie_ext_capability_regs_bench.sv ***
// Self-checking bench for the extended capability bank.
// Assumes the bank answers every host access one cycle later.
`timescale 1ns/100ps
module pcie_ext_capability_regs_bench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg cfg_req = 1'b0;
    reg cfg_write = 1'b0;
    reg [2:0] cfg_port = 3'h0;
    reg [11:0] cfg_addr = 12'h000;
    reg [31:0] cfg_wdata = 32'h0;
    wire cfg_ack, cfg_hit, init_write;
    wire [31:0] cfg_rdata, init_wdata;
    wire [2:0] init_port;
    wire [11:0] init_addr;
    wire [23:0] vc_arb_select;
    integer num_errors = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer seed = 19986;
    integer i;
    reg [33:0] n;
    reg [33:0] notes[$];
    reg [31:0] sn_lo, sn_hi;
    reg [31:0] ent[0:7];

    always #5 clk = ~clk;
    pcie_ext_capability_regs dut_u (.clk(clk), .rstn(rstn), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .init_write(init_write),
        .init_port(init_port), .init_addr(init_addr), .init_wdata(init_wdata),
        .vc_arb_select(vc_arb_select));
    eeprom_init_model init_u (.clk(clk), .init_write(init_write), .init_port(init_port),
        .init_addr(init_addr), .init_wdata(init_wdata));

    task check(input [32:0] seen, input [32:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // One host access; the note holds read flag, expected hit and expected data
    task acc(input w, input [2:0] p, input [11:0] a, input [31:0] d, input h, input [31:0] e);
        begin
            @(negedge clk);
            cfg_req = 1'b1;
            cfg_write = w;
            cfg_port = p;
            cfg_addr = a;
            cfg_wdata = d;
            notes.push_back({!w, h, e});
            @(negedge clk);
            cfg_req = 1'b0;
            cfg_wdata = ~d;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        cycles = cycles + 1;
        if (cycles > 3000) begin
            num_errors = num_errors + 1;
            tally_and_finish;
        end
        if (cfg_ack === 1'b1) begin
            n = notes.pop_front();
            if (n[33]) check({cfg_hit, cfg_rdata}, n[32:0]);
            else check({cfg_hit, 32'h0}, {n[32], 32'h0});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        acc(0, 1, 12'h13C, 0, 1, 32'h0);
        acc(0, 1, 12'h144, 0, 1, 32'h1);
        acc(0, 1, 12'h154, 0, 1, 32'h0);
        acc(0, 0, 12'h100, 0, 1, 32'hFB41_0003);
        acc(0, 0, 12'h138, 0, 1, 32'h1481_0004);
        acc(0, 0, 12'h148, 0, 1, 32'h0001_0002);
        acc(0, 0, 12'h14C, 0, 1, 32'h800);
        acc(0, 6, 12'h14C, 0, 1, 32'h0);
        acc(0, 0, 12'h158, 0, 1, 32'h3);
        acc(0, 6, 12'h158, 0, 1, 32'h1);
        acc(0, 2, 12'h200, 0, 0, 32'h0);
        sn_lo = $random(seed);
        sn_hi = $random(seed);
        init_u.load(3'h5, 12'h104, sn_lo);
        init_u.load(3'h5, 12'h108, sn_hi);
        acc(1, 0, 12'h104, ~sn_lo, 1, 0);
        for (i = 0; i < 8; i = i + 1) begin
            acc(0, i[2:0], 12'h104, 0, 1, sn_lo);
            acc(0, i[2:0], 12'h108, 0, 1, sn_hi);
        end
        for (i = 0; i < 8; i = i + 1) begin
            ent[i] = $random(seed);
            init_u.load(3'h2, 12'h13C, {ent[i][31:8], i[7:0]});
        end
        for (i = 7; i >= 0; i = i - 1) begin
            acc(1, 2, 12'h13C, i, 1, 0);
            acc(0, 2, 12'h140, 0, 1, {11'h0, ent[i][28:8]});
        end
        acc(1, 2, 12'h13C, 32'hFFFF_FF09, 1, 0);
        acc(0, 2, 12'h13C, 0, 1, 32'h09);
        acc(0, 2, 12'h140, 0, 1, 0);
        acc(0, 3, 12'h140, 0, 1, 0);
        acc(1, 1, 12'h154, 32'hFFFF_FFFF, 1, 0);
        acc(0, 1, 12'h154, 0, 1, 32'hE);
        acc(0, 4, 12'h154, 0, 1, 0);
        check({9'h0, vc_arb_select}, 33'h38);
        init_u.load(3'h3, 12'h144, 32'h0);
        acc(1, 3, 12'h144, 32'h1, 1, 0);
        acc(0, 3, 12'h144, 0, 1, 0);
        rstn = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        acc(0, 2, 12'h13C, 0, 1, 0);
        acc(0, 1, 12'h154, 0, 1, 0);
        repeat (3) @(negedge clk);
        tally_and_finish;
    end
endmodule
